/* File: hdl/pdt_trace_top.sv */
// Instruction pipeline model with the fetch and pipe-advance trace outputs.
`timescale 1ns/1ps
// Behaviour
// R1: One low cycle on fetch trace marks a bus cycle feeding the pipeline.
// R2: Two low cycles on fetch trace mark a flush and its refilling fetch.
// R3: Fetches are signalled whatever the privilege level.
// R4: Flush fetch followed at once by a fetch gives three continuous low cycles.
// R5: The tracker samples fetch trace on two rising edges after the strobe.
// R6: On slower bus cycles fetch trace goes high between indications.
// R7: Three-stage queue; buffer stage never decodes, data leaves from decode and execute.
// R8: Decode stage supplies opcode, extension and immediate data; execute holds running opcode.
// R9: One low cycle on pipe trace marks decode data consumed; buffer refills decode.
// R10: Two low cycles mark instruction start with a full pipeline advance.
// R11: A buffered word moves on into empty stages without an advance request.
// R12: Each advance sets the receiving valid bit and clears the supplying one.
// R13: Pipe trace runs on the system clock, not on bus timing.
// R14: The tracker samples pipe trace on the falling clock edge.
// R15: Every execute stage load is an instruction start.
// R16: Immediate start with second advance keeps pipe trace low across both.
// R17: The tracker splits merged pipe indications and resyncs when idle; the tracker here counts a merged run as one run.
// R18: Loop recirculation stops fetch indications; pipe indications carry on.
// R19: Both traces are active low and stay high when nothing is indicated.
module pdt_trace_top
#(
   parameter int W = pdt_pkg::WORD_W
)
(
   input wire logic core_clk,
   input wire logic rst,
   input wire pdt_pkg::pdt_fetch_t fetchIn,
   input wire pdt_pkg::pdt_exec_t execIn,
   output logic fetch_trace_n,
   output logic pipe_advance_trace_n,
   output logic [W-1:0] decodeWord,
   output logic [W-1:0] executeWord,
   output pdt_pkg::pdt_valid_t stageValid,
   output logic bufferFree,
   output logic instrStart
);
   import pdt_pkg::*;

   logic [W-1:0] stageWord [STAGE_N];
   logic [W-1:0] stageIn [STAGE_N];
   logic [STAGE_N-1:0] stageLoad;
   logic [STAGE_N-1:0] stageClear;
   logic [STAGE_N-1:0] stageVal;
   logic flush;
   logic anyStart;
   logic decFree;
   logic moveBD;
   logic moveDE;
   logic [1:0] fetchLen;
   logic [1:0] pipeLen;
   logic fetchBusy;
   logic pipeBusy;
   logic instrStart_reg;
   logic fetchIdle_reg;
   logic pipeIdle_reg;

   // A flushing fetch empties the queue and restarts it from the new word.
   assign flush = fetchIn.valid && fetchIn.flush;
   // An immediate-data start advances the stages exactly as a plain start does.
   assign anyStart = execIn.start || execIn.startImm;

   // Decode can take a word when empty, or when its word is used this cycle.
   assign decFree = !stageVal[STAGE_DEC] || execIn.consume || anyStart;
   // Buffer into decode on an advance, or by itself when decode is empty.
   assign moveBD = stageVal[STAGE_BUF] && decFree && !flush; // R9 R10 R11
   // Decode into execute only on a start, or by itself when execute is empty.
   assign moveDE = stageVal[STAGE_DEC] && (anyStart || !stageVal[STAGE_EXE]) && !flush; // R10 R11

   // Stage controls share one process so that each control vector has a single driver.
   // Buffer: filled only from the bus or the loop, never decoded here.
   // Decode: takes the buffer word and is invalidated once its data is used.
   // Execute: holds the running opcode until a start replaces it or a flush invalidates it.
   always_comb
   begin
      stageIn[STAGE_BUF] = fetchIn.word; // R7
      stageLoad[STAGE_BUF] = fetchIn.valid;
      stageClear[STAGE_BUF] = moveBD || flush; // R12
      stageIn[STAGE_DEC] = stageWord[STAGE_BUF];
      stageLoad[STAGE_DEC] = moveBD; // R12
      stageClear[STAGE_DEC] = flush || moveDE || execIn.consume || anyStart; // R9 R12
      stageIn[STAGE_EXE] = stageWord[STAGE_DEC];
      stageLoad[STAGE_EXE] = moveDE; // R15
      stageClear[STAGE_EXE] = flush;
   end

   // The three stages share one register module; load wins over clear inside it.
   generate
      for (genvar s = 0; s < STAGE_N; s++)
      begin : g_stage
         pdt_stage_reg #(
            .W(W)
         ) u_stage (
            .core_clk(core_clk),
            .rst(rst),
            .load(stageLoad[s]),
            .clear(stageClear[s]),
            .dIn(stageIn[s]),
            .word(stageWord[s]),
            .valid(stageVal[s])
         );
      end
   endgenerate

   // Immediate data and extension words come from decode; execute shows the opcode.
   assign decodeWord = stageWord[STAGE_DEC]; // R8
   assign executeWord = stageWord[STAGE_EXE]; // R8
   assign stageValid = '{bufValid: stageVal[STAGE_BUF], decValid: stageVal[STAGE_DEC],
                         exeValid: stageVal[STAGE_EXE]};
   // The prefetcher may only deliver a word when the buffer will have room for it.
   assign bufferFree = !stageVal[STAGE_BUF] || moveBD;

   // Fetch indication length; privilege is not looked at, so every fetch counts.
   // Recirculated loop words reach the queue but are not bus fetches and stay silent.
   always_comb
   begin
      if (!fetchIn.valid || fetchIn.recirc) // R18
         fetchLen = LEN_NONE;
      else if (fetchIn.flush)
         fetchLen = LEN_FLUSH; // R2
      else
         fetchLen = LEN_FETCH; // R1 R3
   end

   // Pipe indication length, driven from pipeline events only, never from bus timing.
   // An immediate start already carries its second advance, so it runs three cycles.
   always_comb
   begin
      if (moveDE && execIn.startImm)
         pipeLen = LEN_MERGED; // R16
      else if (moveDE)
         pipeLen = LEN_START; // R10 R15
      else if (execIn.consume)
         pipeLen = LEN_ADVANCE; // R9
      else
         pipeLen = LEN_NONE; // R13 R18
   end

   // Fetch trace shaper; merges a flush run with an immediately following fetch.
   pdt_pulse_shaper u_fetch_shaper (
      .core_clk(core_clk),
      .rst(rst),
      .reqLen(fetchLen),
      .traceN(fetch_trace_n), // R4 R6 R19
      .busy(fetchBusy)
   );

   // Pipe trace shaper on the system clock alone.
   pdt_pulse_shaper u_pipe_shaper (
      .core_clk(core_clk),
      .rst(rst),
      .reqLen(pipeLen),
      .traceN(pipe_advance_trace_n), // R13 R19
      .busy(pipeBusy)
   );

   // Instruction start flag, registered on the same edge as the execute load.
   always_ff @(posedge core_clk)
   begin
      if (rst)
         instrStart_reg <= 1'b0;
      else
         instrStart_reg <= moveDE; // R15
   end

   assign instrStart = instrStart_reg;

   // Helper state for the checks below: a trace counts as idle when it is high
   // now and nothing was asked of its shaper in the previous cycle.
   always_ff @(posedge core_clk)
   begin
      if (rst)
      begin
         fetchIdle_reg <= 1'b1;
         pipeIdle_reg <= 1'b1;
      end
      else
      begin
         fetchIdle_reg <= (fetchLen == LEN_NONE) && !fetchBusy;
         pipeIdle_reg <= (pipeLen == LEN_NONE) && !pipeBusy;
      end
   end

   // Sequence of a single fetch request made on an idle fetch trace.
   sequence fetchAlone;
      fetchLen == LEN_FETCH && fetch_trace_n && fetchIdle_reg;
   endsequence

   // Sequence of a flush request made on an idle fetch trace.
   sequence flushAlone;
      fetchLen == LEN_FLUSH && fetch_trace_n && fetchIdle_reg;
   endsequence

   // Flush fetch followed by a fetch one bus cycle of two clocks later.
   sequence flushThenFetch;
      flushAlone ##1 fetchLen == LEN_NONE ##1 fetchLen == LEN_FETCH;
   endsequence

   fetch_single_a: assert property ( // R1
      @(posedge core_clk) disable iff (rst)
      fetchAlone |=> !fetch_trace_n ##1 (fetch_trace_n || $past(fetchLen) != LEN_NONE))
      else $error("Fetch indication did not go low for one cycle.");

   fetch_flush_a: assert property ( // R2
      @(posedge core_clk) disable iff (rst)
      flushAlone |=> !fetch_trace_n [*2])
      else $error("Flush indication did not hold low for two cycles.");

   fetch_merge_a: assert property ( // R4
      @(posedge core_clk) disable iff (rst)
      flushThenFetch |-> !fetch_trace_n ##1 !fetch_trace_n)
      else $error("Flush and following fetch were not one three-cycle run.");

   fetch_gap_a: assert property ( // R6
      @(posedge core_clk) disable iff (rst)
      fetchAlone ##1 fetchLen == LEN_NONE |=> fetch_trace_n)
      else $error("Fetch trace did not return high between indications.");

   loop_quiet_a: assert property ( // R18
      @(posedge core_clk) disable iff (rst)
      fetchIn.valid && fetchIn.recirc && fetch_trace_n && fetchIdle_reg
      |=> fetch_trace_n)
      else $error("Recirculated loop word produced a fetch indication.");

   decode_refill_a: assert property ( // R9
      @(posedge core_clk) disable iff (rst)
      execIn.consume && !anyStart && !flush && !moveDE
      |=> stageVal[STAGE_DEC] == $past(stageVal[STAGE_BUF]))
      else $error("Decode stage validity did not follow buffer after use.");

   start_pulse_a: assert property ( // R10
      @(posedge core_clk) disable iff (rst)
      moveDE && !execIn.startImm && pipe_advance_trace_n && pipeIdle_reg
      |=> !pipe_advance_trace_n [*2] ##1 (pipe_advance_trace_n || $past(pipeLen) != LEN_NONE
          || $past(pipeLen, 2) != LEN_NONE))
      else $error("Instruction start was not a two-cycle pipe indication.");

   imm_merge_a: assert property ( // R16
      @(posedge core_clk) disable iff (rst)
      moveDE && execIn.startImm && pipe_advance_trace_n && pipeIdle_reg
      |=> !pipe_advance_trace_n [*3])
      else $error("Immediate start with second advance was not merged.");

   auto_move_a: assert property ( // R11
      @(posedge core_clk) disable iff (rst)
      stageVal[STAGE_BUF] && !stageVal[STAGE_DEC] && !flush
      |=> stageVal[STAGE_DEC] ##0 decodeWord == $past(stageWord[STAGE_BUF]))
      else $error("Buffered word did not move into an empty decode stage.");

   valid_hand_a: assert property ( // R12
      @(posedge core_clk) disable iff (rst)
      moveBD && !fetchIn.valid |=> stageVal[STAGE_DEC] && !stageVal[STAGE_BUF])
      else $error("Advance did not move the validity bit forward.");

   exec_start_a: assert property ( // R15
      @(posedge core_clk) disable iff (rst)
      $changed(executeWord) |-> instrStart)
      else $error("Execute stage changed without an instruction start.");

   fetch_idle_a: assert property ( // R19
      @(posedge core_clk) disable iff (rst)
      fetchIdle_reg && fetchLen == LEN_NONE |=> fetch_trace_n)
      else $error("Fetch trace low with nothing to indicate.");

   pipe_idle_a: assert property ( // R19
      @(posedge core_clk) disable iff (rst)
      pipeIdle_reg && pipeLen == LEN_NONE |=> pipe_advance_trace_n)
      else $error("Pipe trace low with nothing to indicate.");

   // A lone use of decode data is one low cycle; only a new request may extend it.
   consume_pulse_a: assert property ( // R9
      @(posedge core_clk) disable iff (rst)
      execIn.consume && !moveDE && pipe_advance_trace_n && pipeIdle_reg
      |=> !pipe_advance_trace_n ##1 (pipe_advance_trace_n || $past(pipeLen) != LEN_NONE))
      else $error("Decode data use was not a one-cycle pipe indication.");

   // A start moves decode into execute and buffer into decode in the same edge.
   full_advance_a: assert property ( // R10
      @(posedge core_clk) disable iff (rst)
      anyStart && stageVal[STAGE_DEC] && stageVal[STAGE_BUF] && !flush
      |=> executeWord == $past(decodeWord) && decodeWord == $past(stageWord[STAGE_BUF]))
      else $error("Instruction start did not advance the whole pipeline.");

   // Every execute load carries the decode word and is flagged as a start.
   exec_load_a: assert property ( // R15
      @(posedge core_clk) disable iff (rst)
      stageLoad[STAGE_EXE] |=> instrStart && executeWord == $past(decodeWord))
      else $error("Execute load was not flagged as an instruction start.");

   // After a flush only the refilling word is left, waiting in the buffer.
   flush_empty_a: assert property ( // R2
      @(posedge core_clk) disable iff (rst)
      flush |=> stageVal[STAGE_BUF] && !stageVal[STAGE_DEC] && !stageVal[STAGE_EXE])
      else $error("Flush did not leave only the new word in the buffer stage.");

   // The buffer never feeds execute directly; only a valid decode word gets there.
   exe_source_a: assert property ( // R7
      @(posedge core_clk) disable iff (rst)
      stageLoad[STAGE_EXE] |-> stageVal[STAGE_DEC] && !flush)
      else $error("Execute stage loaded without a valid decode word.");

endmodule // pdt_trace_top

/* File: hdl/pdt_pkg.sv */
// Shared constants and carrier types for the pipeline trace signal block.
package pdt_pkg;

   // Width of one instruction word held by a pipeline stage.
   localparam int WORD_W = 16;

   // Number of pipeline stages and their positions in the stage arrays.
   localparam int STAGE_N = 3;
   localparam int STAGE_BUF = 0;
   localparam int STAGE_DEC = 1;
   localparam int STAGE_EXE = 2;

   // Low-pulse lengths, in clock cycles, requested from a trace shaper.
   localparam logic [1:0] LEN_NONE = 2'h0;
   localparam logic [1:0] LEN_FETCH = 2'h1;
   localparam logic [1:0] LEN_FLUSH = 2'h2;
   localparam logic [1:0] LEN_ADVANCE = 2'h1;
   localparam logic [1:0] LEN_START = 2'h2;
   localparam logic [1:0] LEN_MERGED = 2'h3;

   // Width of the shaper's pending-cycle counter; holds a merged run with margin.
   localparam int CNT_W = 3;

   // Reset values: trace pins negated (high), stages empty, word cleared.
   localparam logic TRACE_IDLE = 1'b1;
   localparam logic VALID_RST = 1'b0;
   localparam logic [WORD_W-1:0] WORD_RST = 16'h0000;

   // One word delivered to the pipeline, by a bus fetch or by loop recirculation.
   typedef struct packed {
      logic valid;
      logic flush;
      logic recirc;
      logic [WORD_W-1:0] word;
   } pdt_fetch_t;

   // Requests from the execution unit to advance the pipeline.
   typedef struct packed {
      logic consume;
      logic start;
      logic startImm;
   } pdt_exec_t;

   // Validity of the three stages, buffer first.
   typedef struct packed {
      logic bufValid;
      logic decValid;
      logic exeValid;
   } pdt_valid_t;

endpackage

/* File: hdl/pdt_stage_reg.sv */
// One instruction pipeline stage: a word register with its validity bit.
`timescale 1ns/1ps
module pdt_stage_reg
#(
   parameter int W = pdt_pkg::WORD_W
)
(
   input wire logic core_clk,
   input wire logic rst,
   input wire logic load,
   input wire logic clear,
   input wire logic [W-1:0] dIn,
   output logic [W-1:0] word,
   output logic valid
);
   import pdt_pkg::*;

   logic [W-1:0] wordReg;
   logic validReg;

   // The word only changes on a load, so a cleared stage keeps its stale word harmlessly.
   always_ff @(posedge core_clk)
   begin
      if (rst)
         wordReg <= W'(0);
      else if (load)
         wordReg <= dIn;
   end

   // A load wins over a clear, so a stage that supplies data and refills in one cycle stays valid.
   always_ff @(posedge core_clk)
   begin
      if (rst)
         validReg <= VALID_RST;
      else if (load)
         validReg <= 1'b1;
      else if (clear)
         validReg <= 1'b0;
   end

   assign word = wordReg;
   assign valid = validReg;

endmodule // pdt_stage_reg

/* File: hdl/pdt_pulse_shaper.sv */
// Turns requested low-pulse lengths into an active-low trace pin that merges adjacent runs.
`timescale 1ns/1ps
module pdt_pulse_shaper
(
   input wire logic core_clk,
   input wire logic rst,
   input wire logic [1:0] reqLen,
   output logic traceN,
   output logic busy
);
   import pdt_pkg::*;

   logic [CNT_W-1:0] remain_reg;
   logic [CNT_W-1:0] remain_next;
   logic traceN_reg;

   // The cycle being shown is retired and the new request is appended behind it.
   // A request that lands on the last low cycle therefore extends the run with no gap.
   always_comb
   begin
      remain_next = (remain_reg != '0) ? CNT_W'(remain_reg - 1'b1) : '0;
      remain_next = CNT_W'(remain_next + CNT_W'(reqLen));
   end

   // Pending low cycles still to be shown on the pin.
   always_ff @(posedge core_clk)
   begin
      if (rst)
         remain_reg <= '0;
      else
         remain_reg <= remain_next;
   end

   // The pin comes from a flip-flop; it is low exactly while cycles are pending.
   always_ff @(posedge core_clk)
   begin
      if (rst)
         traceN_reg <= TRACE_IDLE;
      else
         traceN_reg <= (remain_next == '0);
   end

   assign traceN = traceN_reg;
   assign busy = (remain_reg > CNT_W'(1));

endmodule // pdt_pulse_shaper

/* File: testbench/pdt_trace_tracker.sv */
// External trace tracker that measures the low runs on both trace pins.
`timescale 1ns/1ps
module pdt_trace_tracker
(
   input wire logic core_clk,
   input wire logic rst,
   input wire logic fetch_trace_n,
   input wire logic pipe_advance_trace_n,
   output logic [2:0] fetchLen,
   output logic [7:0] fetchRuns,
   output logic [2:0] pipeLen,
   output logic [7:0] pipeRuns
);
   logic [2:0] fetchCnt;
   logic [2:0] pipeCnt;

   // Fetch trace is sampled on rising edges, as on a two-clock bus.
   always_ff @(posedge core_clk)
   begin
      if (rst)
      begin
         fetchCnt <= 3'h0;
         fetchLen <= 3'h0;
         fetchRuns <= 8'h00;
      end
      else if (fetch_trace_n === 1'b0)
         fetchCnt <= fetchCnt + 3'h1;
      else
      begin
         // A run ends on the first high sample; idle resynchronises the count.
         if (fetchCnt != 3'h0)
         begin
            fetchLen <= fetchCnt;
            fetchRuns <= fetchRuns + 8'h01;
         end
         fetchCnt <= 3'h0;
      end
   end

   // Pipe trace is sampled on the falling edge, away from its launching edge.
   always_ff @(negedge core_clk)
   begin
      if (rst)
      begin
         pipeCnt <= 3'h0;
         pipeLen <= 3'h0;
         pipeRuns <= 8'h00;
      end
      else if (pipe_advance_trace_n === 1'b0)
         pipeCnt <= pipeCnt + 3'h1;
      else
      begin
         if (pipeCnt != 3'h0)
         begin
            pipeLen <= pipeCnt;
            pipeRuns <= pipeRuns + 8'h01;
         end
         pipeCnt <= 3'h0;
      end
   end
endmodule // pdt_trace_tracker

/* File: testbench/pipeline_trace_signals_bench.sv */
// Self-checking bench for the fetch and pipe-advance trace outputs.
`timescale 1ns/1ps
module pipeline_trace_signals_bench;
   import pdt_pkg::*;
   logic core_clk;
   logic rst;
   pdt_fetch_t fetchIn;
   pdt_exec_t execIn;
   logic fetch_trace_n;
   logic pipe_advance_trace_n;
   logic [15:0] decodeWord;
   logic [15:0] executeWord;
   pdt_valid_t stageValid;
   logic bufferFree;
   logic instrStart;
   logic [2:0] fetchLen;
   logic [2:0] pipeLen;
   logic [7:0] fetchRuns;
   logic [7:0] pipeRuns;
   logic [7:0] fr0;
   logic [7:0] pr0;
   int s0;
   int nStart;
   int nFail;
   int checksDone;

   pdt_trace_top pdt_trace_top_inst (.core_clk(core_clk), .rst(rst), .fetchIn(fetchIn),
      .execIn(execIn), .fetch_trace_n(fetch_trace_n),
      .pipe_advance_trace_n(pipe_advance_trace_n), .decodeWord(decodeWord),
      .executeWord(executeWord), .stageValid(stageValid), .bufferFree(bufferFree),
      .instrStart(instrStart));

   pdt_trace_tracker pdt_trace_tracker_inst (.core_clk(core_clk), .rst(rst),
      .fetch_trace_n(fetch_trace_n), .pipe_advance_trace_n(pipe_advance_trace_n),
      .fetchLen(fetchLen), .fetchRuns(fetchRuns), .pipeLen(pipeLen), .pipeRuns(pipeRuns));

   // Clock at 200 MHz.
   initial
   begin
      core_clk = 1'b0;
      forever #2.5 core_clk = ~core_clk;
   end

   // Counts instruction-start pulses so each scenario can compare the delta.
   always @(posedge core_clk)
   begin
      if (rst)
         nStart <= 0;
      else if (instrStart === 1'b1)
         nStart <= nStart + 1;
   end

   task automatic check_val(input logic [15:0] got, input logic [15:0] exp, input string what);
      checksDone++;
      if (got !== exp)
      begin
         $display("MISMATCH at %0t: %s got %h expected %h", $time, what, got, exp);
         nFail++;
      end
   endtask

   task automatic report_and_stop;
      $display("checks %0d, mismatches %0d", checksDone, nFail);
      if (nFail == 0 && checksDone > 0)
         $display("== PASSED ==");
      else
         $display("== FAILED ==");
      $finish;
   endtask

   // Waits for six quiet cycles on both pins so the tracker has closed every run.
   task automatic waitIdle;
      int k;
      int quiet;
      k = 0;
      quiet = 0;
      while (quiet < 6)
      begin
         @(posedge core_clk);
         #1;
         quiet = (fetch_trace_n === 1'b1 && pipe_advance_trace_n === 1'b1) ? quiet + 1 : 0;
         k++;
         if (k > 60)
         begin
            $display("MISMATCH at %0t: trace pins never went idle", $time);
            nFail++;
            report_and_stop;
         end
      end
   endtask

   // One-cycle word delivery; the buffer is checked free just before the word is driven.
   task automatic sendFetch(input logic flush, input logic recirc, input logic [15:0] word);
      @(posedge core_clk);
      #1;
      check_val({15'h0, bufferFree}, 16'h0001, "buffer free");
      fetchIn <= '{valid: 1'b1, flush: flush, recirc: recirc, word: word};
      @(posedge core_clk);
      #1;
      fetchIn <= '0;
   endtask

   task automatic pulseExec(input logic [2:0] req);
      @(posedge core_clk);
      #1;
      execIn <= req;
      @(posedge core_clk);
      #1;
      execIn <= '0;
   endtask

   task automatic snap;
      fr0 = fetchRuns;
      pr0 = pipeRuns;
      s0 = nStart;
   endtask

   // Compares run counts and start pulses against the snapshot.
   task automatic checkDelta(input int df, input int dp, input int ds);
      check_val(16'(fetchRuns - fr0), 16'(df), "fetch runs");
      check_val(16'(pipeRuns - pr0), 16'(dp), "pipe runs");
      check_val(16'(nStart - s0), 16'(ds), "instruction starts");
   endtask

   task automatic testReset;
      check_val({14'h0, fetch_trace_n, pipe_advance_trace_n}, 16'h0003, "idle pins");
      check_val({13'h0, stageValid}, 16'h0000, "valid after reset");
      check_val({15'h0, bufferFree}, 16'h0001, "free after reset");
      $display("test reset done");
   endtask

   // Single fetch into an empty pipe moves on into execute, leaving only that stage valid, and starts the instruction.
   task automatic testFetch;
      snap;
      sendFetch(1'b0, 1'b0, 16'h1234);
      waitIdle;
      checkDelta(1, 1, 1);
      check_val({13'h0, fetchLen}, 16'h0001, "fetch mark");
      check_val({13'h0, pipeLen}, 16'h0002, "fill start mark");
      check_val(executeWord, 16'h1234, "execute word");
      check_val({13'h0, stageValid}, 16'h0001, "valid bits");
      $display("test fetch done");
   endtask

   // Flush with a fetch two cycles later merges into one three-cycle run.
   task automatic testFlush;
      snap;
      sendFetch(1'b1, 1'b0, 16'haaaa);
      sendFetch(1'b0, 1'b0, 16'h5555);
      waitIdle;
      checkDelta(1, 1, 1);
      check_val({13'h0, fetchLen}, 16'h0003, "merged flush run");
      check_val({13'h0, pipeLen}, 16'h0002, "refill start");
      check_val(executeWord, 16'haaaa, "execute after flush");
      check_val(decodeWord, 16'h5555, "decode after flush");
      check_val({13'h0, stageValid}, 16'h0003, "valid bits");
      $display("test flush done");
   endtask

   // Spaced fetches stay separate; a consume moves the buffer word into decode.
   task automatic testSpaced;
      snap;
      sendFetch(1'b0, 1'b0, 16'h3333);
      repeat (3) @(posedge core_clk);
      pulseExec(3'b100);
      repeat (3) @(posedge core_clk);
      sendFetch(1'b0, 1'b0, 16'h4444);
      waitIdle;
      checkDelta(2, 1, 0);
      check_val({13'h0, fetchLen}, 16'h0001, "separate fetch");
      check_val({13'h0, pipeLen}, 16'h0001, "consume mark");
      check_val(decodeWord, 16'h3333, "decode after consume");
      check_val(executeWord, 16'haaaa, "execute kept");
      check_val({13'h0, stageValid}, 16'h0007, "valid bits");
      $display("test spaced done");
   endtask

   task automatic testStart;
      snap;
      pulseExec(3'b010);
      waitIdle;
      checkDelta(0, 1, 1);
      check_val({13'h0, pipeLen}, 16'h0002, "start mark");
      check_val(executeWord, 16'h3333, "full advance exe");
      check_val(decodeWord, 16'h4444, "full advance dec");
      check_val({13'h0, stageValid}, 16'h0003, "valid bits");
      $display("test start done");
   endtask

   task automatic testImm;
      snap;
      pulseExec(3'b001);
      waitIdle;
      checkDelta(0, 1, 1);
      check_val({13'h0, pipeLen}, 16'h0003, "merged pipe run");
      check_val(executeWord, 16'h4444, "immediate start exe");
      check_val({13'h0, stageValid}, 16'h0001, "valid bits");
      $display("test immediate done");
   endtask

   // Recirculated word gives no fetch mark while pipe marks carry on.
   task automatic testRecirc;
      snap;
      sendFetch(1'b0, 1'b1, 16'h5a5a);
      waitIdle;
      check_val(decodeWord, 16'h5a5a, "recirculated word");
      pulseExec(3'b010);
      waitIdle;
      checkDelta(0, 1, 1);
      check_val({13'h0, pipeLen}, 16'h0002, "start in loop");
      check_val(executeWord, 16'h5a5a, "loop execute");
      $display("test recirculation done");
   endtask

   initial
   begin
      rst = 1'b1;
      fetchIn = '0;
      execIn = '0;
      nFail = 0;
      checksDone = 0;
      repeat (16) @(posedge core_clk);
      #1;
      rst <= 1'b0;
      @(posedge core_clk);
      #1;
      testReset;
      testFetch;
      testFlush;
      testSpaced;
      testStart;
      testImm;
      testRecirc;
      report_and_stop;
   end
endmodule // pipeline_trace_signals_bench
